// [rtl/lcp_pkg.sv]
// constants, states and types shared by both ends of the config port link
// Function
// - seven straps set channel and watchdog defaults
// - straps sampled on every reset, loaded
// - low strap zeroes enable, base, irq
// - high strap gives fixed channel base, irq
// - watchdog strap gives base 0x442, irq 0
// - strap defaults stay writable by host
// - registers reached through index then data port
// - port strap picks 0x4e/0x4f or 0x2e/0x2f
// - port strap pulled up, default 0x2e/0x2f
// - two consecutive key writes enter config
// - key straps pick one of four keys
// - 0xaa on index port leaves config
// - index 0x07 selects logical device
// - index 0x25 selects 24 or 48 MHz
// - per channel 0xf6 sets fifo mode
// - enable register 0x30 enables channel
// - 0x20/0x21 return device id bytes
// - 0x23/0x24 return vendor id bytes
// - frame strobe and 4-bit lad carry cycles
// - active low bus reset, serial irq line
package lcp_pkg;
	localparam logic [7:0] IDX_LDEV_SEL = 8'h07;
	localparam logic [7:0] IDX_DEVID_HI = 8'h20;
	localparam logic [7:0] IDX_DEVID_LO = 8'h21;
	localparam logic [7:0] IDX_VENID_HI = 8'h23;
	localparam logic [7:0] IDX_VENID_LO = 8'h24;
	localparam logic [7:0] IDX_CLKSEL = 8'h25;
	localparam logic [7:0] IDX_ENABLE = 8'h30;
	localparam logic [7:0] IDX_BASE_HI = 8'h60;
	localparam logic [7:0] IDX_BASE_LO = 8'h61;
	localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
	localparam logic [7:0] IDX_FIFO = 8'hf6;
	localparam logic [15:0] PORT_IDX_4E = 16'h004e;
	localparam logic [15:0] PORT_DAT_4F = 16'h004f;
	localparam logic [15:0] PORT_IDX_2E = 16'h002e;
	localparam logic [15:0] PORT_DAT_2F = 16'h002f;
	localparam logic [7:0] KEY_00 = 8'h77;
	localparam logic [7:0] KEY_01 = 8'ha0;
	localparam logic [7:0] KEY_10 = 8'h87;
	localparam logic [7:0] KEY_11 = 8'h67;
	localparam logic [7:0] EXIT_KEY = 8'haa;
	localparam logic [7:0] LDEV_WATCHDOG = 8'h08;
	localparam logic [7:0] LDEV_RST = 8'h00;
	localparam logic [7:0] CLKSEL_RST = 8'h00;
	localparam logic [7:0] FIFO_RST = 8'h00;
	localparam logic [7:0] EN_ON = 8'h01;
	localparam logic [7:0] CHA_BASE_HI = 8'h03;
	localparam logic [7:0] CHA_BASE_LO = 8'hf8;
	localparam logic [7:0] CHA_ALT_LO = 8'he0;
	localparam logic [7:0] CHA_IRQ = 8'h03;
	localparam logic [7:0] CHB_BASE_HI = 8'h02;
	localparam logic [7:0] CHB_BASE_LO = 8'hf8;
	localparam logic [7:0] CHB_ALT_LO = 8'he0;
	localparam logic [7:0] CHB_IRQ = 8'h04;
	localparam logic [7:0] CHC_BASE_HI = 8'h03;
	localparam logic [7:0] CHC_BASE_LO = 8'he8;
	localparam logic [7:0] CHC_IRQ = 8'h05;
	localparam logic [7:0] CHD_BASE_HI = 8'h02;
	localparam logic [7:0] CHD_BASE_LO = 8'he8;
	localparam logic [7:0] CHD_IRQ = 8'h09;
	localparam logic [7:0] WDOG_BASE_HI = 8'h04;
	localparam logic [7:0] WDOG_BASE_LO = 8'h42;
	localparam logic [7:0] WDOG_IRQ = 8'h00;
	localparam logic [3:0] LAD_START = 4'h0;
	localparam logic [3:0] CYC_IO_RD = 4'h0;
	localparam logic [3:0] CYC_IO_WR = 4'h2;
	localparam logic [3:0] SYNC_READY = 4'h0;
	localparam logic [3:0] LAD_IDLE = 4'hf;
	localparam logic [7:0] HR_ADDR = 8'h00;
	localparam logic [7:0] HR_WDATA = 8'h04;
	localparam logic [7:0] HR_CTRL = 8'h08;
	localparam logic [7:0] HR_STATUS = 8'h0c;
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_WR_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_TMO_BIT = 1;
	localparam int ST_RDATA_LSB = 8;
	localparam int SYNC_WAIT_CYC = 8;
	typedef enum logic [3:0] {
		DS_IDLE = 4'b0000, DS_CYC = 4'b0001, DS_ADR = 4'b0011, DS_WDAT = 4'b0010,
		DS_TAR1 = 4'b0110, DS_TAR2 = 4'b0111, DS_SYNC = 4'b0101, DS_RDAT = 4'b0100,
		DS_TAR3 = 4'b1100, DS_TAR4 = 4'b1101
	} lcp_dev_st_e;
	typedef enum logic [3:0] {
		HS_IDLE = 4'b0000, HS_START = 4'b0001, HS_CYC = 4'b0011, HS_ADR = 4'b0010,
		HS_WDAT = 4'b0110, HS_TAR1 = 4'b0111, HS_TAR2 = 4'b0101, HS_SWAIT = 4'b0100,
		HS_RDAT = 4'b1100, HS_TAR3 = 4'b1101, HS_TAR4 = 4'b1111, HS_ABORT = 4'b1110
	} lcp_host_st_e;
endpackage

// [rtl/lcp_lpc_if.sv]
// link between the bus host end and the config port device end
`timescale 1ns/1ps
interface lcp_lpc_if;
	logic lframe_n;
	logic lreset_n;
	logic [3:0] lad_h;
	logic lad_h_oe;
	logic [3:0] lad_d;
	logic lad_d_oe;
	logic serirq_d;
	logic serirq_d_oe;
	logic [3:0] lad;
	logic serirq;
	// wire level: whoever enables drives, the host if both do, otherwise the pull-ups win
	assign lad = lad_h_oe ? lad_h : (lad_d_oe ? lad_d : 4'hf);
	assign serirq = serirq_d_oe ? serirq_d : 1'b1;
	modport host (output lframe_n, output lreset_n, output lad_h, output lad_h_oe, input lad, input serirq);
	modport dev (input lframe_n, input lreset_n, input lad, output lad_d, output lad_d_oe,
		output serirq_d, output serirq_d_oe);
endinterface

// [rtl/lcp_dev_end.sv]
// device end: strap capture, key unlock, indirect config registers
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module lcp_dev_end
	import lcp_pkg::*;
#(
	parameter logic [7:0] DEV_ID_HI = 8'h5a, // arbitrary value
	parameter logic [7:0] DEV_ID_LO = 8'h01, // arbitrary value
	parameter logic [7:0] VEN_ID_HI = 8'h12, // arbitrary value
	parameter logic [7:0] VEN_ID_LO = 8'h34, // arbitrary value
	parameter int BANKS = 5
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic ce,
	lcp_lpc_if.dev lpc,
	input wire logic port_pair_strap,
	input wire logic key_strap_high,
	input wire logic key_strap_low,
	input wire logic chan_a_strap,
	input wire logic chan_a_alt_strap,
	input wire logic chan_b_strap,
	input wire logic chan_b_alt_strap,
	input wire logic chan_c_strap,
	input wire logic chan_d_strap,
	input wire logic watchdog_strap,
	output logic cfg_active,
	output logic [BANKS-1:0] dev_enable,
	output logic ref_clk_48
);
	lcp_dev_st_e state_reg, state_next;
	logic [1:0] cnt_reg, cnt_next;
	logic is_wr_reg;
	logic [15:0] addr_reg;
	logic [3:0] wlo_reg;
	logic [7:0] rdata_reg;
	logic [3:0] lad_out_reg, lad_out_next;
	logic lad_oe_reg, lad_oe_next;
	logic serirq_oe_reg;
	logic port_hi_reg;
	logic [7:0] key_reg;
	logic cfg_reg, key_seen_reg;
	logic [7:0] index_reg, lsel_reg, clksel_reg;
	logic [7:0] en_reg [BANKS];
	logic [7:0] bhi_reg [BANKS];
	logic [7:0] blo_reg [BANKS];
	logic [7:0] irq_reg [BANKS];
	logic [7:0] fifo_reg [BANKS];
	logic [31:0] dflt_w [BANKS];
	logic [7:0] rd_val;

	// either reset restarts the block and recaptures the straps
	wire rst = sys_rst | ~lpc.lreset_n;
	wire [7:0] key_w = key_strap_high ? (key_strap_low ? KEY_11 : KEY_10)
		: (key_strap_low ? KEY_01 : KEY_00);

	// default word {enable, base high, base low, irq}; low strap gives all zero
	function automatic logic [31:0] dflt(input logic on, input logic [7:0] hi, input logic [7:0] lo,
		input logic [7:0] irq);
		dflt = on ? {EN_ON, hi, lo, irq} : 32'h0;
	endfunction

	// the primary strap wins the base low byte when both are high
	assign dflt_w[0] = dflt(chan_a_strap | chan_a_alt_strap, CHA_BASE_HI,
		chan_a_strap ? CHA_BASE_LO : CHA_ALT_LO, CHA_IRQ);
	assign dflt_w[1] = dflt(chan_b_strap | chan_b_alt_strap, CHB_BASE_HI,
		chan_b_strap ? CHB_BASE_LO : CHB_ALT_LO, CHB_IRQ);
	assign dflt_w[2] = dflt(chan_c_strap, CHC_BASE_HI, CHC_BASE_LO, CHC_IRQ);
	assign dflt_w[3] = dflt(chan_d_strap, CHD_BASE_HI, CHD_BASE_LO, CHD_IRQ);
	assign dflt_w[4] = dflt(watchdog_strap, WDOG_BASE_HI, WDOG_BASE_LO, WDOG_IRQ);

	// port decode; the address is complete only once its last nibble arrives
	wire [15:0] addr_w = (state_reg == DS_ADR) ? {addr_reg[11:0], lpc.lad} : addr_reg;
	wire [15:0] idx_port = port_hi_reg ? PORT_IDX_2E : PORT_IDX_4E;
	wire [15:0] dat_port = port_hi_reg ? PORT_DAT_2F : PORT_DAT_4F;
	wire idx_hit = addr_w == idx_port;
	wire dat_hit = addr_w == dat_port;
	// index writes are always claimed so the key can get through
	wire claim = (idx_hit & (is_wr_reg | cfg_reg)) | (dat_hit & cfg_reg);
	wire [7:0] wd = {lpc.lad, wlo_reg};
	wire wr_done = (state_reg == DS_WDAT) & cnt_reg[0];
	wire bank_ok = (lsel_reg < 8'h04) | (lsel_reg == LDEV_WATCHDOG);
	wire [2:0] bank = (lsel_reg == LDEV_WATCHDOG) ? 3'd4 : lsel_reg[2:0];
	wire per_dev = (index_reg >= IDX_ENABLE) & bank_ok;

	// read selection for the data port and the index port
	always_comb begin
		rd_val = 8'h00;
		if (idx_hit) begin
			rd_val = index_reg;
		end else begin
			case (index_reg)
				IDX_LDEV_SEL: rd_val = lsel_reg;
				IDX_DEVID_HI: rd_val = DEV_ID_HI;
				IDX_DEVID_LO: rd_val = DEV_ID_LO;
				IDX_VENID_HI: rd_val = VEN_ID_HI;
				IDX_VENID_LO: rd_val = VEN_ID_LO;
				IDX_CLKSEL: rd_val = clksel_reg;
				IDX_ENABLE: rd_val = per_dev ? en_reg[bank] : 8'h00;
				IDX_BASE_HI: rd_val = per_dev ? bhi_reg[bank] : 8'h00;
				IDX_BASE_LO: rd_val = per_dev ? blo_reg[bank] : 8'h00;
				IDX_IRQ_SEL: rd_val = per_dev ? irq_reg[bank] : 8'h00;
				IDX_FIFO: rd_val = per_dev ? fifo_reg[bank] : 8'h00;
				default: rd_val = 8'h00;
			endcase
		end
	end

	// cycle decoder; a frame strobe anywhere restarts or aborts the cycle
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		if (!lpc.lframe_n) begin
			state_next = (lpc.lad == LAD_START) ? DS_CYC : DS_IDLE;
			cnt_next = 2'd0;
		end else begin
			case (state_reg)
				DS_IDLE: state_next = DS_IDLE;
				DS_CYC: state_next = (lpc.lad == CYC_IO_RD || lpc.lad == CYC_IO_WR) ? DS_ADR : DS_IDLE;
				DS_ADR: begin
					cnt_next = cnt_reg + 2'd1;
					if (cnt_reg == 2'd3) begin
						cnt_next = 2'd0;
						state_next = is_wr_reg ? DS_WDAT : (claim ? DS_TAR1 : DS_IDLE);
					end
				end
				DS_WDAT: begin
					cnt_next = cnt_reg + 2'd1;
					if (cnt_reg[0]) begin
						cnt_next = 2'd0;
						state_next = claim ? DS_TAR1 : DS_IDLE;
					end
				end
				DS_TAR1: state_next = DS_TAR2;
				DS_TAR2: state_next = DS_SYNC;
				DS_SYNC: state_next = is_wr_reg ? DS_TAR3 : DS_RDAT;
				DS_RDAT: begin
					cnt_next = cnt_reg + 2'd1;
					if (cnt_reg[0]) begin
						cnt_next = 2'd0;
						state_next = DS_TAR3;
					end
				end
				DS_TAR3: state_next = DS_TAR4;
				DS_TAR4: state_next = DS_IDLE;
				default: state_next = DS_IDLE;
			endcase
		end
	end

	// pin drive follows the state being entered so the pins come from flops
	always_comb begin
		lad_out_next = LAD_IDLE;
		lad_oe_next = 1'b0;
		case (state_next)
			DS_SYNC: begin
				lad_out_next = SYNC_READY;
				lad_oe_next = 1'b1;
			end
			DS_RDAT: begin
				lad_out_next = cnt_next[0] ? rdata_reg[7:4] : rdata_reg[3:0];
				lad_oe_next = 1'b1;
			end
			DS_TAR3: lad_oe_next = 1'b1;
			default: lad_oe_next = 1'b0;
		endcase
	end

	// link side state
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= DS_IDLE;
			cnt_reg <= 2'd0;
			is_wr_reg <= 1'b0;
			addr_reg <= 16'h0000;
			wlo_reg <= 4'h0;
			rdata_reg <= 8'h00;
			lad_out_reg <= LAD_IDLE;
			lad_oe_reg <= 1'b0;
			serirq_oe_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			lad_out_reg <= lad_out_next;
			lad_oe_reg <= lad_oe_next;
			if (state_reg == DS_CYC) is_wr_reg <= lpc.lad == CYC_IO_WR;
			if (state_reg == DS_ADR) addr_reg <= addr_w;
			if (state_reg == DS_WDAT && !cnt_reg[0]) wlo_reg <= lpc.lad;
			if (state_reg == DS_TAR2) rdata_reg <= rd_val;
		end
	end

	// config state; sync reset reloads the straps, a clocked capture
	always_ff @(posedge core_clk) begin
		if (rst) begin
			port_hi_reg <= port_pair_strap;
			key_reg <= key_w;
			cfg_reg <= 1'b0;
			key_seen_reg <= 1'b0;
			index_reg <= 8'h00;
			lsel_reg <= LDEV_RST;
			clksel_reg <= CLKSEL_RST;
			for (int i = 0; i < BANKS; i++) begin
				{en_reg[i], bhi_reg[i], blo_reg[i], irq_reg[i]} <= dflt_w[i];
				fifo_reg[i] <= FIFO_RST;
			end
		end else if (ce && wr_done && lpc.lframe_n) begin
			if (idx_hit && !cfg_reg) begin
				key_seen_reg <= (wd == key_reg) & ~key_seen_reg;
				if (wd == key_reg && key_seen_reg) cfg_reg <= 1'b1;
			end else if (idx_hit) begin
				if (wd == EXIT_KEY) cfg_reg <= 1'b0;
				else index_reg <= wd;
			end else begin
				key_seen_reg <= 1'b0;
				if (dat_hit && cfg_reg) begin
					case (index_reg)
						IDX_LDEV_SEL: lsel_reg <= wd;
						IDX_CLKSEL: clksel_reg <= wd;
						default: begin
							if (per_dev) begin
								case (index_reg)
									IDX_ENABLE: en_reg[bank] <= wd;
									IDX_BASE_HI: bhi_reg[bank] <= wd;
									IDX_BASE_LO: blo_reg[bank] <= wd;
									IDX_IRQ_SEL: irq_reg[bank] <= wd;
									IDX_FIFO: fifo_reg[bank] <= wd;
									default: ;
								endcase
							end
						end
					endcase
				end
			end
		end
	end

	// outputs; the serial irq line stays released, no sources live here
	assign lpc.lad_d = lad_out_reg;
	assign lpc.lad_d_oe = lad_oe_reg;
	assign lpc.serirq_d = 1'b0;
	assign lpc.serirq_d_oe = serirq_oe_reg;
	assign cfg_active = cfg_reg;
	assign ref_clk_48 = clksel_reg[0];
	for (genvar g = 0; g < BANKS; g++) begin : g_en
		assign dev_enable[g] = en_reg[g][0];
	end
endmodule

// [rtl/lcp_host_end.sv]
// host end: wishbone orders turned into single byte i/o cycles on the link
`timescale 1ns/1ps
module lcp_host_end
	import lcp_pkg::*;
#(
	parameter int SYNC_WAIT = SYNC_WAIT_CYC
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic ce,
	lcp_lpc_if.host lpc,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	lcp_host_st_e state_reg, state_next;
	logic [1:0] cnt_reg, cnt_next;
	logic [15:0] addr_reg;
	logic [7:0] wdata_reg, rdata_reg;
	logic dir_wr_reg, busy_reg, tmo_reg, ack_reg, rst_n_reg;
	logic [31:0] dat_reg;
	logic [7:0] tcnt_reg;
	logic [3:0] lad_reg, lad_next;
	logic oe_reg, oe_next, frame_n_reg, frame_n_next;

	// bus decode; every access is acked, unmapped reads give zero
	wire acc = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire wr = acc & wb_we_i;
	wire go = wr & (wb_adr_i == HR_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_GO_BIT] & ~busy_reg;
	wire done = (state_reg == HS_TAR4) | (state_reg == HS_ABORT);
	wire [31:0] status_w = {16'h0, rdata_reg, 6'h0, tmo_reg, busy_reg};
	wire [31:0] rd_w = (wb_adr_i == HR_ADDR) ? {16'h0, addr_reg}
		: (wb_adr_i == HR_WDATA) ? {24'h0, wdata_reg}
		: (wb_adr_i == HR_CTRL) ? {30'h0, dir_wr_reg, 1'b0}
		: (wb_adr_i == HR_STATUS) ? status_w : 32'h0;

	// cycle sequencer, one byte per order
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			HS_IDLE: if (go) state_next = HS_START;
			HS_START: state_next = HS_CYC;
			HS_CYC: state_next = HS_ADR;
			HS_ADR: begin
				cnt_next = cnt_reg + 2'd1;
				if (cnt_reg == 2'd3) state_next = dir_wr_reg ? HS_WDAT : HS_TAR1;
			end
			HS_WDAT: begin
				cnt_next = cnt_reg + 2'd1;
				if (cnt_reg[0]) begin
					cnt_next = 2'd0;
					state_next = HS_TAR1;
				end
			end
			HS_TAR1: state_next = HS_TAR2;
			HS_TAR2: state_next = HS_SWAIT;
			HS_SWAIT: begin
				if (lpc.lad == SYNC_READY) state_next = dir_wr_reg ? HS_TAR3 : HS_RDAT;
				else if (tcnt_reg == 8'(SYNC_WAIT - 1)) state_next = HS_ABORT;
			end
			HS_RDAT: begin
				cnt_next = cnt_reg + 2'd1;
				if (cnt_reg[0]) begin
					cnt_next = 2'd0;
					state_next = HS_TAR3;
				end
			end
			HS_TAR3: state_next = HS_TAR4;
			HS_TAR4: state_next = HS_IDLE;
			HS_ABORT: state_next = HS_IDLE;
			default: state_next = HS_IDLE;
		endcase
	end

	// pin values for the state being entered, so pins leave flops
	always_comb begin
		frame_n_next = 1'b1;
		lad_next = LAD_IDLE;
		oe_next = 1'b1;
		case (state_next)
			HS_START: begin
				frame_n_next = 1'b0;
				lad_next = LAD_START;
			end
			HS_CYC: lad_next = dir_wr_reg ? CYC_IO_WR : CYC_IO_RD;
			HS_ADR: lad_next = addr_reg[4'(4 * (3 - int'(cnt_next))) +: 4];
			HS_WDAT: lad_next = cnt_next[0] ? wdata_reg[7:4] : wdata_reg[3:0];
			HS_TAR1: lad_next = LAD_IDLE;
			HS_ABORT: frame_n_next = 1'b0;
			default: oe_next = 1'b0;
		endcase
	end

	// link side registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= HS_IDLE;
			cnt_reg <= 2'd0;
			tcnt_reg <= 8'h00;
			frame_n_reg <= 1'b1;
			lad_reg <= LAD_IDLE;
			oe_reg <= 1'b0;
			rst_n_reg <= 1'b0;
			rdata_reg <= 8'h00;
			busy_reg <= 1'b0;
			tmo_reg <= 1'b0;
		end else if (ce) begin
			rst_n_reg <= 1'b1;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			frame_n_reg <= frame_n_next;
			lad_reg <= lad_next;
			oe_reg <= oe_next;
			tcnt_reg <= (state_reg == HS_SWAIT) ? tcnt_reg + 8'h01 : 8'h00;
			if (state_reg == HS_RDAT && !cnt_reg[0]) rdata_reg[3:0] <= lpc.lad;
			if (state_reg == HS_RDAT && cnt_reg[0]) rdata_reg[7:4] <= lpc.lad;
			if (go) busy_reg <= 1'b1;
			else if (done) busy_reg <= 1'b0;
			if (go) tmo_reg <= 1'b0;
			else if (state_reg == HS_ABORT) tmo_reg <= 1'b1;
		end
	end

	// software side registers; order fields are frozen while busy
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			addr_reg <= PORT_IDX_2E;
			wdata_reg <= 8'h00;
			dir_wr_reg <= 1'b0;
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
		end else if (ce) begin
			ack_reg <= acc;
			if (acc) dat_reg <= rd_w;
			if (wr && !busy_reg && wb_adr_i == HR_ADDR) begin
				if (wb_sel_i[0]) addr_reg[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1]) addr_reg[15:8] <= wb_dat_i[15:8];
			end
			if (wr && !busy_reg && wb_adr_i == HR_WDATA && wb_sel_i[0]) wdata_reg <= wb_dat_i[7:0];
			if (wr && !busy_reg && wb_adr_i == HR_CTRL && wb_sel_i[0]) dir_wr_reg <= wb_dat_i[CTRL_WR_BIT];
		end
	end

	assign lpc.lframe_n = frame_n_reg;
	assign lpc.lreset_n = rst_n_reg;
	assign lpc.lad_h = lad_reg;
	assign lpc.lad_h_oe = oe_reg;
	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
endmodule

// [bench/lcp_link_checker.sv]
// link checker: wire timing, turnaround and config entry on the joined link
`timescale 1ns/1ps
module lcp_link_checker
	import lcp_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic lframe_n,
	input wire logic lreset_n,
	input wire logic lad_h_oe,
	input wire logic [3:0] lad_d,
	input wire logic lad_d_oe,
	input wire logic serirq_d_oe,
	input wire logic [3:0] lad,
	input wire logic serirq,
	input wire logic cfg_active
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// the first device cycle is always a ready sync, after a full turnaround
	sequence dev_sync_s;
		$rose(lad_d_oe) ##0 lad_d == SYNC_READY;
	endsequence
	sequence turned_s;
		!$past(lad_h_oe) && $past(lad_h_oe, 2);
	endsequence
	no_overlap_a: assert property (!(lad_h_oe && lad_d_oe)) else $error("both ends drive lad");
	serirq_idle_a: assert property (!serirq_d_oe |-> serirq) else $error("serirq not idle high");
	host_frame_a: assert property (!lframe_n |-> lad_h_oe) else $error("frame low with lad released");
	frame_start_a: assert property ((!lframe_n && lad == LAD_START) |=> lframe_n && lad_h_oe &&
		(lad == CYC_IO_RD || lad == CYC_IO_WR)) else $error("bad cycle type after start");
	sync_turn_a: assert property ($rose(lad_d_oe) |-> dev_sync_s and turned_s)
		else $error("device answer without sync or turnaround");
	drive_len_a: assert property (lad_d_oe [*4] |=> !lad_d_oe) else $error("device drives too long");
	turn_gap_a: assert property ($fell(lad_d_oe) |-> !lad_h_oe) else $error("no release cycle after device");
	reset_quiet_a: assert property (!lreset_n |=> !cfg_active && !lad_d_oe)
		else $error("device active in bus reset");
	key_entry_a: assert property ($rose(cfg_active) |-> ##[1:4] lad_d_oe)
		else $error("config entered outside a key write");
endmodule

// [bench/tb_top.sv]
// top bench: host end and device end joined, driven over wishbone
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
	$display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_top
	import lcp_pkg::*;
;
	logic core_clk, sys_rst, cyc, stb, wwe;
	logic [7:0] wadr;
	logic [3:0] wsel;
	logic [31:0] wdat, wb_dat_o;
	logic wb_ack_o, cfg_active, ref_clk_48;
	logic [4:0] dev_enable;
	logic ps, k1, k0, ce, cb;
	logic [15:0] ip, dp;
	int n_fail, check_count;
	lcp_lpc_if lpc();
	lcp_host_end lcp_host_end_i (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .lpc(lpc), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(wadr), .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o));
	// channel a both straps, b alt only, c low, d high, watchdog tied to the port strap
	lcp_dev_end lcp_dev_end_i (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .lpc(lpc),
		.port_pair_strap(ps), .key_strap_high(k1), .key_strap_low(k0), .chan_a_strap(1'b1),
		.chan_a_alt_strap(1'b1), .chan_b_strap(cb), .chan_b_alt_strap(1'b1), .chan_c_strap(1'b0),
		.chan_d_strap(1'b1), .watchdog_strap(ps), .cfg_active(cfg_active), .dev_enable(dev_enable),
		.ref_clk_48(ref_clk_48));
	lcp_link_checker lcp_link_checker_i (.core_clk(core_clk), .sys_rst(sys_rst), .lframe_n(lpc.lframe_n),
		.lreset_n(lpc.lreset_n), .lad_h_oe(lpc.lad_h_oe), .lad_d(lpc.lad_d), .lad_d_oe(lpc.lad_d_oe),
		.serirq_d_oe(lpc.serirq_d_oe), .lad(lpc.lad), .serirq(lpc.serirq), .cfg_active(cfg_active));
	initial begin
		core_clk = 0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// one classic cycle; request held up to the rising edge at which ack is sampled high
	// no cycle count is assumed here, only the watchdog ends a hung wait
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		wwe <= we;
		wadr <= a;
		wsel <= 4'hf;
		wdat <= d;
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// one byte i/o cycle on the link, polled to completion
	task automatic io(input logic we, input logic [15:0] a, input logic [7:0] d, output logic [7:0] rb,
		output logic tmo);
		logic [31:0] r, c;
		int n;
		c = 32'h0;
		c[CTRL_GO_BIT] = 1'b1;
		c[CTRL_WR_BIT] = we;
		wb(1'b1, HR_ADDR, {16'h0, a}, r);
		wb(1'b1, HR_WDATA, {24'h0, d}, r);
		wb(1'b1, HR_CTRL, c, r);
		n = 0;
		do begin wb(1'b0, HR_STATUS, 32'h0, r); n++; end while (r[ST_BUSY_BIT] !== 1'b0 && n < 40);
		`CHK(r[ST_BUSY_BIT], 1'b0)
		rb = r[ST_RDATA_LSB +: 8];
		tmo = r[ST_TMO_BIT];
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] rb;
		logic t;
		io(1'b1, a, d, rb, t);
	endtask
	// indexed read through the data port
	task automatic rdi(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] rb;
		logic t;
		wr(ip, idx);
		io(1'b0, dp, 8'h00, rb, t);
		`CHK(t, 1'b0)
		`CHK(rb, exp)
	endtask
	task automatic do_reset(input logic p, input logic h, input logic l);
		@(posedge core_clk);
		sys_rst <= 1'b1; ps <= p; k1 <= h; k0 <= l;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		ip = p ? PORT_IDX_2E : PORT_IDX_4E;
		dp = p ? PORT_DAT_2F : PORT_DAT_4F;
	endtask
	logic [7:0] lsel_t [5] = '{8'h00, 8'h01, 8'h02, 8'h03, LDEV_WATCHDOG};
	logic [7:0] idx_t [4] = '{IDX_ENABLE, IDX_BASE_HI, IDX_BASE_LO, IDX_IRQ_SEL};
	logic [7:0] exp_t [5][4] = '{'{8'h01, 8'h03, 8'hf8, 8'h03}, '{8'h01, 8'h02, 8'he0, 8'h04},
		'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h02, 8'he8, 8'h09}, '{8'h01, 8'h04, 8'h42, 8'h00}};
	logic [7:0] key_t [4] = '{8'h77, 8'ha0, 8'h87, 8'h67};
	// the watchdog span lies far beyond the few thousand cycles the tests need
	initial begin
		#(50 * 60000);
		n_fail++;
		complete_run();
	end
	initial begin
		logic [7:0] rb;
		logic t;
		n_fail = 0; check_count = 0;
		sys_rst = 1'b1; cyc = 0; stb = 0; wwe = 0; wadr = 8'h00; wsel = 4'h0; wdat = 32'h0;
		ps = 1'b1;
		k1 = 1'b1;
		k0 = 1'b1;
		ce = 1'b1;
		cb = 1'b0;
		do_reset(1'b1, 1'b1, 1'b1);
		`CHK(dev_enable, 5'b11011)
		io(1'b0, dp, 8'h00, rb, t);
		`CHK(t, 1'b1)
		wr(ip, KEY_11);
		wr(ip, 8'h55);
		wr(ip, KEY_11);
		`CHK(cfg_active, 1'b0)
		wr(ip, KEY_11);
		`CHK(cfg_active, 1'b1)
		$display("test key entry done");
		rdi(IDX_DEVID_HI, 8'h5a);
		rdi(IDX_DEVID_LO, 8'h01);
		rdi(IDX_VENID_HI, 8'h12);
		rdi(IDX_VENID_LO, 8'h34);
		// in config mode the index port reads back the last index written
		io(1'b0, ip, 8'h00, rb, t);
		`CHK(rb, IDX_VENID_LO)
		for (int i = 0; i < 5; i++) begin
			wr(ip, IDX_LDEV_SEL);
			wr(dp, lsel_t[i]);
			rdi(IDX_LDEV_SEL, lsel_t[i]);
			for (int j = 0; j < 4; j++) rdi(idx_t[j], exp_t[i][j]);
		end
		$display("test strap defaults done");
		wr(ip, IDX_LDEV_SEL);
		wr(dp, 8'h02);
		wr(ip, IDX_ENABLE);
		wr(dp, EN_ON);
		`CHK(dev_enable[2], 1'b1)
		wr(ip, IDX_BASE_HI);
		wr(dp, 8'hab);
		rdi(IDX_BASE_HI, 8'hab);
		wr(ip, IDX_LDEV_SEL);
		wr(dp, 8'h03);
		rdi(IDX_BASE_HI, CHD_BASE_HI);
		wr(ip, IDX_LDEV_SEL);
		wr(dp, 8'h01);
		wr(ip, IDX_FIFO);
		wr(dp, 8'h03);
		rdi(IDX_FIFO, 8'h03);
		wr(ip, IDX_LDEV_SEL);
		wr(dp, 8'h00);
		rdi(IDX_FIFO, FIFO_RST);
		wr(ip, IDX_CLKSEL);
		wr(dp, 8'h01);
		`CHK(ref_clk_48, 1'b1)
		rdi(IDX_CLKSEL, 8'h01);
		wr(ip, EXIT_KEY);
		`CHK(cfg_active, 1'b0)
		io(1'b0, dp, 8'h00, rb, t);
		`CHK(t, 1'b1)
		$display("test overrides and exit done");
		// each key strap code, with the port strap toggling and straps reloaded
		for (int k = 0; k < 4; k++) begin
			do_reset(k[0], k[1], k[0]);
			`CHK(ref_clk_48, 1'b0)
			`CHK(dev_enable[4], k[0])
			wr(ip, key_t[k]);
			wr(ip, key_t[k]);
			`CHK(cfg_active, 1'b1)
			rdi(IDX_LDEV_SEL, LDEV_RST);
			wr(ip, EXIT_KEY);
		end
		$display("test key and port straps done");
		complete_run();
	end
endmodule
